//--- rtl/bsp_pkg.sv
// Purpose: Shared constants for the burst SRAM synchronous port, device end and controller end.
// Assumes: The x36 variant; in_clk/out_clk edges are one-cycle strobes on a single i_clk.
// Notes:   The x8 nibble variant is the same lane logic with narrower lanes.
package bsp_pkg;
    localparam int ADDR_W    = 19;
    localparam int DATA_W    = 36;   // x36 word width
    localparam int LANES     = 4;    // Byte write selects
    localparam int LANE_W    = 9;    // Bits per byte lane
    localparam int BURST     = 4;    // Beats per access
    localparam int BEAT_W    = 2;    // Beat counter width
    localparam int MEM_IDX_W = 3;    // Modelled locations, low address bits
    localparam int MEM_WORDS = BURST << MEM_IDX_W;
    localparam int RD_PIPE_W = 6;    // Controller read return tracker
    localparam int RD_FIRST  = 2;    // Tracker tap of first returned beat
    localparam int RD_LAST   = 5;    // Tracker tap of last returned beat
    localparam logic [LANES-1:0] SEL_IDLE = 4'hf;  // All lanes deselected
    localparam logic             PORT_OFF = 1'h1;  // Port select deasserted

    // Upcoming in_clk_pos slot of the controller
    typedef enum logic [1:0] {
        BSP_SLOT_RD = 2'h1,
        BSP_SLOT_WR = 2'h2
    } bsp_slot_e;

    // Merge a beat into a stored word, lanes with a low select take new data
    function automatic logic [DATA_W-1:0] bsp_lane_merge(input logic [DATA_W-1:0] old_w,
                                                         input logic [DATA_W-1:0] new_w,
                                                         input logic [LANES-1:0]  sel_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < LANES; l++) begin
            if (!sel_n[l]) begin
                res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

    // Word index of one beat of one location
    function automatic logic [MEM_IDX_W+BEAT_W-1:0] bsp_word_idx(input logic [ADDR_W-1:0] addr,
                                                                input logic [BEAT_W-1:0] beat);
        return {addr[MEM_IDX_W-1:0], beat};
    endfunction
endpackage

//--- rtl/bsp_link_if.sv
// Purpose: Pin-level link between the memory controller and the burst SRAM.
// Assumes: Clock edges are one-cycle strobes valid in the i_clk domain.
// Notes:   Read data is split into value and output enable; the bench reads the enable directly and the value through the controller.
`timescale 1ns/100ps
interface bsp_link_if;
    // Clock edge strobes
    logic                                 in_clk_pos;
    logic                                 in_clk_neg;
    logic                                 out_clk_pos;
    logic                                 out_clk_neg;
    logic                                 single_clk;
    // Command and write data
    logic [bsp_pkg::ADDR_W-1:0]           addr;
    logic                                 read_port_sel_n;
    logic                                 write_port_sel_n;
    logic [bsp_pkg::DATA_W-1:0]           wdata;
    logic [bsp_pkg::LANES-1:0]            byte_write_sel_n;
    // Read data
    logic [bsp_pkg::DATA_W-1:0]           rdata;
    logic                                 rdata_oe;

    modport dev (
        input  in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg, single_clk,
        input  addr, read_port_sel_n, write_port_sel_n, wdata, byte_write_sel_n,
        output rdata, rdata_oe
    );
    modport ctl (
        output in_clk_pos, in_clk_neg, out_clk_pos, out_clk_neg, single_clk,
        output addr, read_port_sel_n, write_port_sel_n, wdata, byte_write_sel_n,
        input  rdata, rdata_oe
    );
endinterface

//--- rtl/bsp_sram_dev.sv
// Purpose: Device end, the synchronous port of a four-beat burst SRAM with a small array.
// Assumes: Selects and data are stable in the cycle that carries the matching edge strobe.
// Notes:   Only the low address bits index the modelled array; upper bits are accepted.
//          A burst owns its port for two in_clk_pos periods.
//          A select in the second period is dropped, not queued.
//          A read racing a write to one word returns the old word.
//          Variant is x36; narrower variants use the same lane merge.
`timescale 1ns/100ps
module bsp_sram_dev (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // Link to the controller
    bsp_link_if.dev   link,
    // Status towards the user side
    output logic      o_rd_busy,
    output logic      o_wr_busy
);
    localparam int W_IDX = bsp_pkg::MEM_IDX_W + bsp_pkg::BEAT_W;

    // Array and port state
    // Cleared at reset so unwritten words read as zero
    logic [bsp_pkg::DATA_W-1:0] mem_reg [0:bsp_pkg::MEM_WORDS-1];
    logic [bsp_pkg::DATA_W-1:0] mem_next [0:bsp_pkg::MEM_WORDS-1];
    logic                       rd_skip_reg,  rd_skip_next;
    logic                       wr_skip_reg,  wr_skip_next;
    logic                       rd_pend_reg,  rd_pend_next;
    logic [bsp_pkg::ADDR_W-1:0] rd_paddr_reg, rd_paddr_next;
    logic [bsp_pkg::ADDR_W-1:0] rd_addr_reg,  rd_addr_next;
    logic [bsp_pkg::BEAT_W-1:0] rd_beat_reg,  rd_beat_next;
    logic [bsp_pkg::DATA_W-1:0] q_reg,        q_next;
    logic                       oe_reg,       oe_next;
    logic                       wr_act_reg,   wr_act_next;
    logic [bsp_pkg::ADDR_W-1:0] wr_addr_reg,  wr_addr_next;
    logic [bsp_pkg::BEAT_W-1:0] wr_beat_reg,  wr_beat_next;

    // Decoded edges and accepted commands
    logic             rd_take;
    logic             wr_take;
    logic             wr_beat_edge;
    logic             launch_pos;
    logic             launch_neg;
    logic             wr_en;
    logic [W_IDX-1:0] wr_idx;
    logic [W_IDX-1:0] rd_idx;

    // Command acceptance: one access per port every second in_clk_pos
    // The skip flag guards the slot a running burst owns,
    // so a repeated select cannot restart the beat count.
    assign rd_take = link.in_clk_pos && !link.read_port_sel_n && !rd_skip_reg;
    assign wr_take = link.in_clk_pos && !link.write_port_sel_n && !wr_skip_reg;

    // Either input strobe carries a running write beat
    assign wr_beat_edge = link.in_clk_pos || link.in_clk_neg;

    // Word of the read beat being launched
    assign rd_idx = bsp_pkg::bsp_word_idx(rd_addr_reg, rd_beat_reg);

    // Output launch edges, input clocks stand in when running single clock
    // The two clock pairs are separate pins even when driven alike
    assign launch_pos = link.single_clk ? link.in_clk_pos : link.out_clk_pos;
    assign launch_neg = link.single_clk ? link.in_clk_neg : link.out_clk_neg;

    // Write beat selection, first beat rides with the write select
    // Beats 1 to 3 follow on the next three strobes
    always_comb begin
        wr_en  = 1'b0;
        wr_idx = '0;
        if (wr_take) begin
            wr_en  = 1'b1;
            wr_idx = bsp_pkg::bsp_word_idx(link.addr, '0);
        end else if (wr_act_reg && wr_beat_edge) begin
            wr_en  = 1'b1;
            wr_idx = bsp_pkg::bsp_word_idx(wr_addr_reg, wr_beat_reg);
        end
    end

    // Array next state, masked lanes keep their stored value
    // A read in the same cycle still sees the old word
    always_comb begin
        for (int i = 0; i < bsp_pkg::MEM_WORDS; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en) begin
            mem_next[wr_idx] = bsp_pkg::bsp_lane_merge(mem_reg[wr_idx], link.wdata,
                                                      link.byte_write_sel_n);
        end
    end

    // Write sequencing
    // The beat counter wraps to zero after beat 3,
    // ready for a burst taken on the next free slot
    always_comb begin
        wr_skip_next = wr_skip_reg;
        wr_act_next  = wr_act_reg;
        wr_addr_next = wr_addr_reg;
        wr_beat_next = wr_beat_reg;
        if (link.in_clk_pos) begin
            wr_skip_next = wr_take;          // Second in_clk_pos of a burst is its own
        end
        if (wr_take) begin
            wr_act_next  = 1'b1;
            wr_addr_next = link.addr;
            wr_beat_next = 2'h1;
        end else if (wr_act_reg && wr_beat_edge) begin
            wr_beat_next = bsp_pkg::BEAT_W'(wr_beat_reg + 2'h1);
            if (wr_beat_reg == 2'h3) begin
                wr_act_next = 1'b0;
            end
        end
    end

    // Read sequencing and output drive
    // Beats launch pos, neg, pos, neg; a pos launch at beat 2
    // continues the burst, any other starts a pending read,
    // and with none pending it releases the outputs
    always_comb begin
        rd_skip_next  = rd_skip_reg;
        rd_pend_next  = rd_pend_reg;
        rd_paddr_next = rd_paddr_reg;
        rd_addr_next  = rd_addr_reg;
        rd_beat_next  = rd_beat_reg;
        q_next        = q_reg;
        oe_next       = oe_reg;
        if (launch_pos) begin
            if (rd_beat_reg == 2'h2) begin
                q_next       = mem_reg[rd_idx];
                rd_beat_next = 2'h3;
            end else if (rd_pend_reg) begin
                q_next       = mem_reg[bsp_pkg::bsp_word_idx(rd_paddr_reg, '0)];
                rd_addr_next = rd_paddr_reg;
                rd_beat_next = 2'h1;
                rd_pend_next = 1'b0;
                oe_next      = 1'b1;
            end else begin
                oe_next      = 1'b0;
            end
        end else if (launch_neg && rd_beat_reg[0]) begin
            q_next       = mem_reg[rd_idx];
            rd_beat_next = bsp_pkg::BEAT_W'(rd_beat_reg + 2'h1);
        end
        // Acceptance half, as on the write port
        if (link.in_clk_pos) begin
            rd_skip_next = rd_take;
        end
        if (rd_take) begin
            rd_pend_next  = 1'b1;
            rd_paddr_next = link.addr;
        end
    end

    // Array registers, one word per index
    // Only the written word changes in a cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < bsp_pkg::MEM_WORDS; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < bsp_pkg::MEM_WORDS; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    // Write sequencing registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_skip_reg  <= 1'b0;
            wr_act_reg   <= 1'b0;
            wr_addr_reg  <= '0;
            wr_beat_reg  <= '0;
        end else begin
            wr_skip_reg  <= wr_skip_next;
            wr_act_reg   <= wr_act_next;
            wr_addr_reg  <= wr_addr_next;
            wr_beat_reg  <= wr_beat_next;
        end
    end

    // Read sequencing and output registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_skip_reg  <= 1'b0;
            rd_pend_reg  <= 1'b0;
            rd_paddr_reg <= '0;
            rd_addr_reg  <= '0;
            rd_beat_reg  <= '0;
            q_reg        <= '0;
            oe_reg       <= 1'b0;
        end else begin
            rd_skip_reg  <= rd_skip_next;
            rd_pend_reg  <= rd_pend_next;
            rd_paddr_reg <= rd_paddr_next;
            rd_addr_reg  <= rd_addr_next;
            rd_beat_reg  <= rd_beat_next;
            q_reg        <= q_next;
            oe_reg       <= oe_next;
        end
    end

    // Outputs; read data and enable come straight from flip-flops
    // The busy flags serve the user side only
    // and never feed back into the link logic
    assign link.rdata     = q_reg;
    assign link.rdata_oe  = oe_reg;
    assign o_rd_busy      = oe_reg | rd_pend_reg;
    assign o_wr_busy      = wr_act_reg;
endmodule

//--- rtl/bsp_ctl.sv
// Purpose: Controller end, drives the SRAM port from read and write burst requests.
// Assumes: Input and output clock pairs are strobes from one divider; reads and writes alternate slots.
// Notes:   A request is taken when its ready and request are both high at a clock edge.
`timescale 1ns/100ps
module bsp_ctl (
    // Clock and reset
    input  wire logic                                      i_clk,
    input  wire logic                                      i_rstn,
    // Mode
    input  wire logic                                      i_single_clk,
    // Read request and return
    input  wire logic                                      i_rd_req,
    input  wire logic [bsp_pkg::ADDR_W-1:0]                i_rd_addr,
    output logic                                           o_rd_ready,
    output logic [bsp_pkg::DATA_W-1:0]                     o_rd_data,
    output logic                                           o_rd_valid,
    // Write request
    input  wire logic                                      i_wr_req,
    input  wire logic [bsp_pkg::ADDR_W-1:0]                i_wr_addr,
    input  wire logic [bsp_pkg::BURST*bsp_pkg::DATA_W-1:0] i_wr_data,
    input  wire logic [bsp_pkg::BURST*bsp_pkg::LANES-1:0]  i_wr_sel_n,
    output logic                                           o_wr_ready,
    // Link to the SRAM
    bsp_link_if.ctl                                        link
);
    // Divider and slot state
    logic                       phase_reg,  phase_next;
    bsp_pkg::bsp_slot_e         slot_reg,   slot_next;
    // Pin state
    logic                       rps_n_reg,  rps_n_next;
    logic                       wps_n_reg,  wps_n_next;
    logic [bsp_pkg::ADDR_W-1:0] addr_reg,   addr_next;
    logic [bsp_pkg::DATA_W-1:0] d_reg,      d_next;
    logic [bsp_pkg::LANES-1:0]  sel_reg,    sel_next;
    // Write burst store
    logic [bsp_pkg::BURST*bsp_pkg::DATA_W-1:0] wbuf_reg, wbuf_next;
    logic [bsp_pkg::BURST*bsp_pkg::LANES-1:0]  wsel_reg, wsel_next;
    logic [bsp_pkg::BEAT_W-1:0]                wcnt_reg, wcnt_next;
    // Read return tracking
    logic [bsp_pkg::RD_PIPE_W-1:0] pipe_reg,   pipe_next;
    logic [bsp_pkg::DATA_W-1:0]    rdata_reg,  rdata_next;
    logic                          rvalid_reg, rvalid_next;

    logic k_pos;
    logic rd_take;
    logic wr_take;

    // Edge strobes, phase 0 is in_clk_pos and phase 1 is in_clk_neg
    assign k_pos      = !phase_reg;
    assign o_rd_ready = phase_reg && (slot_reg == bsp_pkg::BSP_SLOT_RD);
    assign o_wr_ready = phase_reg && (slot_reg == bsp_pkg::BSP_SLOT_WR) && (wcnt_reg == 2'h0);
    assign rd_take    = o_rd_ready && i_rd_req;
    assign wr_take    = o_wr_ready && i_wr_req;

    // Next state
    always_comb begin
        phase_next  = !phase_reg;
        slot_next   = slot_reg;
        rps_n_next  = bsp_pkg::PORT_OFF;
        wps_n_next  = bsp_pkg::PORT_OFF;
        addr_next   = addr_reg;
        d_next      = d_reg;
        sel_next    = bsp_pkg::SEL_IDLE;
        wbuf_next   = wbuf_reg;
        wsel_next   = wsel_reg;
        wcnt_next   = wcnt_reg;
        if (k_pos) begin
            case (slot_reg)
                bsp_pkg::BSP_SLOT_RD: slot_next = bsp_pkg::BSP_SLOT_WR;
                bsp_pkg::BSP_SLOT_WR: slot_next = bsp_pkg::BSP_SLOT_RD;
                default:              slot_next = bsp_pkg::BSP_SLOT_RD;
            endcase
        end
        if (rd_take) begin
            rps_n_next = 1'b0;
            addr_next  = i_rd_addr;
        end
        if (wr_take) begin
            wps_n_next = 1'b0;
            addr_next  = i_wr_addr;
            wbuf_next  = i_wr_data;
            wsel_next  = i_wr_sel_n;
            d_next     = i_wr_data[0 +: bsp_pkg::DATA_W];
            sel_next   = i_wr_sel_n[0 +: bsp_pkg::LANES];
            wcnt_next  = 2'h1;
        end else if (wcnt_reg != 2'h0) begin
            d_next    = wbuf_reg[wcnt_reg*bsp_pkg::DATA_W +: bsp_pkg::DATA_W];
            sel_next  = wsel_reg[wcnt_reg*bsp_pkg::LANES +: bsp_pkg::LANES];
            wcnt_next = bsp_pkg::BEAT_W'(wcnt_reg + 2'h1);
        end
    end

    // Read return, beats appear three to six cycles after the read edge
    always_comb begin
        pipe_next   = {pipe_reg[bsp_pkg::RD_PIPE_W-2:0], k_pos && !rps_n_reg};
        rvalid_next = |pipe_reg[bsp_pkg::RD_LAST:bsp_pkg::RD_FIRST];
        rdata_next  = rvalid_next ? link.rdata : rdata_reg;
    end

    // Registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_reg  <= 1'b1;
            slot_reg   <= bsp_pkg::BSP_SLOT_RD;
            rps_n_reg  <= bsp_pkg::PORT_OFF;
            wps_n_reg  <= bsp_pkg::PORT_OFF;
            addr_reg   <= '0;
            d_reg      <= '0;
            sel_reg    <= bsp_pkg::SEL_IDLE;
            wbuf_reg   <= '0;
            wsel_reg   <= '1;
            wcnt_reg   <= '0;
            pipe_reg   <= '0;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            phase_reg  <= phase_next;
            slot_reg   <= slot_next;
            rps_n_reg  <= rps_n_next;
            wps_n_reg  <= wps_n_next;
            addr_reg   <= addr_next;
            d_reg      <= d_next;
            sel_reg    <= sel_next;
            wbuf_reg   <= wbuf_next;
            wsel_reg   <= wsel_next;
            wcnt_reg   <= wcnt_next;
            pipe_reg   <= pipe_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // Link drive, output clock pair follows the input pair
    assign link.in_clk_pos       = k_pos;
    assign link.in_clk_neg       = phase_reg;
    assign link.out_clk_pos      = k_pos;
    assign link.out_clk_neg      = phase_reg;
    assign link.single_clk       = i_single_clk;
    assign link.addr             = addr_reg;
    assign link.read_port_sel_n  = rps_n_reg;
    assign link.write_port_sel_n = wps_n_reg;
    assign link.wdata            = d_reg;
    assign link.byte_write_sel_n = sel_reg;
    assign o_rd_data             = rdata_reg;
    assign o_rd_valid            = rvalid_reg;
endmodule

//--- dv/bsp_link_sva.sv
// Purpose: Concurrent checks on the link between the burst SRAM controller and device ends.
// Assumes: Edge strobes are one-cycle levels in the i_clk domain, as on the link interface.
// Notes:   Instantiated beside the link interface in the bench top; no bind.
`timescale 1ns/100ps
module bsp_link_sva (
    // Clock and reset
    input wire logic                         i_clk,
    input wire logic                         i_rstn,
    // Link signals
    input wire logic                         in_clk_pos,
    input wire logic                         in_clk_neg,
    input wire logic                         out_clk_pos,
    input wire logic                         out_clk_neg,
    input wire logic                         single_clk,
    input wire logic [bsp_pkg::ADDR_W-1:0]   addr,
    input wire logic                         read_port_sel_n,
    input wire logic                         write_port_sel_n,
    input wire logic [bsp_pkg::DATA_W-1:0]   wdata,
    input wire logic [bsp_pkg::LANES-1:0]    byte_write_sel_n,
    input wire logic [bsp_pkg::DATA_W-1:0]   rdata,
    input wire logic                         rdata_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Accepted read and write starts
    sequence rd_take;
        in_clk_pos && !read_port_sel_n;
    endsequence
    sequence wr_take;
        in_clk_pos && !write_port_sel_n;
    endsequence

    chk_rd_burst_four: assert property (rd_take |-> ##3 rdata_oe [*4])
        else $error("read burst did not drive four beats");
    chk_oe_has_cause: assert property ($rose(rdata_oe) |-> $past(in_clk_pos && !read_port_sel_n, 3))
        else $error("read data driven without a read start");
    chk_oe_release: assert property (rd_take ##1 (!(in_clk_pos && !read_port_sel_n)) [*7] |-> ##1 !rdata_oe)
        else $error("read data not released after burst");
    chk_rd_on_pos: assert property (!read_port_sel_n |-> in_clk_pos)
        else $error("read select outside positive input strobe");
    chk_wr_on_pos: assert property (!write_port_sel_n |-> in_clk_pos)
        else $error("write select outside positive input strobe");
    chk_slot_exclusive: assert property (rd_take |-> write_port_sel_n)
        else $error("read and write share one address strobe");
    chk_strobe_alternate: assert property (in_clk_pos |=> in_clk_neg && !in_clk_pos)
        else $error("negative strobe does not follow positive strobe");
    chk_out_pair: assert property (out_clk_pos == in_clk_pos && out_clk_neg == in_clk_neg)
        else $error("output clock pair not driven with input pair");
    chk_mask_window: assert property ((byte_write_sel_n != 4'hf) |-> (!write_port_sel_n
        || $past(!write_port_sel_n, 1) || $past(!write_port_sel_n, 2) || $past(!write_port_sel_n, 3)))
        else $error("byte selects active outside a write burst");
    cover property (rd_take ##2 wr_take);
endmodule

//--- dv/tb_burst_sram_sync_port.sv
// Purpose: Self-checking bench with controller and device ends joined by the link interface.
// Assumes: Array starts all zero; only the low three address bits select a location.
// Notes:   The bench keeps its own copy of the array to work out read results.
`timescale 1ns/100ps
module tb_burst_sram_sync_port;
    logic                                   i_clk;
    logic                                   i_rstn;
    logic                                   i_single_clk;
    logic                                   i_rd_req;
    logic [bsp_pkg::ADDR_W-1:0]             i_rd_addr;
    logic                                   i_wr_req;
    logic [bsp_pkg::ADDR_W-1:0]             i_wr_addr;
    logic [143:0]                           i_wr_data;
    logic [15:0]                            i_wr_sel_n;
    logic                                   o_rd_ready;
    logic [35:0]                            o_rd_data;
    logic                                   o_rd_valid;
    logic                                   o_wr_ready;
    logic                                   o_rd_busy;
    logic                                   o_wr_busy;
    logic [35:0]                            mem [32];
    int                                     num_errors;
    int                                     total_checks;
    int                                     cycles;

    bsp_link_if link ();
    bsp_ctl bsp_ctl_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_single_clk(i_single_clk), .i_rd_req(i_rd_req),
        .i_rd_addr(i_rd_addr), .o_rd_ready(o_rd_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .i_wr_req(i_wr_req), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_wr_sel_n(i_wr_sel_n),
        .o_wr_ready(o_wr_ready), .link(link));
    bsp_sram_dev bsp_sram_dev_inst (.i_clk(i_clk), .i_rstn(i_rstn), .link(link), .o_rd_busy(o_rd_busy),
        .o_wr_busy(o_wr_busy));
    bsp_link_sva bsp_link_sva_inst (.i_clk(i_clk), .i_rstn(i_rstn), .in_clk_pos(link.in_clk_pos),
        .in_clk_neg(link.in_clk_neg), .out_clk_pos(link.out_clk_pos), .out_clk_neg(link.out_clk_neg),
        .single_clk(link.single_clk), .addr(link.addr), .read_port_sel_n(link.read_port_sel_n),
        .write_port_sel_n(link.write_port_sel_n), .wdata(link.wdata),
        .byte_write_sel_n(link.byte_write_sel_n), .rdata(link.rdata), .rdata_oe(link.rdata_oe));

    // Clock and hang guard
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles >= 5000) begin
            num_errors++;
            conclude();
        end
    end

    // Compare and report
    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Lanes with a low select take the new bits
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n, input logic [3:0] s);
        for (int l = 0; l < 4; l++) begin
            if (s[l] == 1'b0) begin
                o[l*9 +: 9] = n[l*9 +: 9];
            end
        end
        return o;
    endfunction

    // One write burst; the request waits through refused cycles
    task automatic do_write(input logic [18:0] a, input logic [143:0] d, input logic [15:0] s);
        @(posedge i_clk);
        i_wr_addr  <= a;
        i_wr_data  <= d;
        i_wr_sel_n <= s;
        i_wr_req   <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            @(negedge i_clk);
            if (o_wr_ready === 1'b1) break;
        end
        @(posedge i_clk);
        i_wr_req <= 1'b0;
        @(negedge i_clk);
        check("wr_sel", {35'h0, link.write_port_sel_n}, 36'h0);
        @(negedge i_clk);
        check("wr_busy", {35'h0, o_wr_busy}, 36'h1);
        for (int b = 0; b < 4; b++) begin
            mem[{a[2:0], b[1:0]}] = merge(mem[{a[2:0], b[1:0]}], d[b*36 +: 36], s[b*4 +: 4]);
        end
    endtask

    // One read burst, four beats judged against the array copy
    task automatic do_read(input logic [18:0] a);
        @(posedge i_clk);
        i_rd_addr <= a;
        i_rd_req  <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            @(negedge i_clk);
            if (o_rd_ready === 1'b1) break;
        end
        @(posedge i_clk);
        i_rd_req <= 1'b0;
        for (int n = 0; n < 12; n++) begin
            @(negedge i_clk);
            if (o_rd_valid === 1'b1) break;
        end
        check("rd_busy", {35'h0, o_rd_busy}, 36'h1);
        check("rd_oe", {35'h0, link.rdata_oe}, 36'h1);
        for (int b = 0; b < 4; b++) begin
            check("rd_valid", {35'h0, o_rd_valid}, 36'h1);
            check("rd_data", o_rd_data, mem[{a[2:0], b[1:0]}]);
            @(negedge i_clk);
        end
        check("rd_oe_off", {35'h0, link.rdata_oe}, 36'h0);
    endtask

    // Full burst written on alternating edges, then read back
    task automatic s_full_burst();
        do_write(19'h5, {36'h4_4444_4444, 36'h3_3333_3333, 36'h2_2222_2222, 36'h1_1111_1111}, 16'h0);
        do_read(19'h5);
    endtask

    // One lane per beat, then a fully masked burst that must change nothing
    task automatic s_lane_masks();
        do_write(19'h5, {4{36'hf_edcb_a987}}, 16'h7bde);
        do_read(19'h5);
        do_write(19'h5, {4{36'h0_0000_0000}}, 16'hffff);
        do_read(19'h5);
    endtask

    // Read and write requested together; upper address bits are not decoded
    task automatic s_concurrent();
        fork
            do_write(19'h7fffa, {36'ha_0000_0003, 36'hb_0000_0002, 36'hc_0000_0001, 36'hd_0000_0000}, 16'h0);
            do_read(19'h5);
        join
        do_read(19'h2);
    endtask

    // Read data launched on the input strobes in single clock mode
    task automatic s_single_clock();
        @(posedge i_clk);
        i_single_clk <= 1'b1;
        do_read(19'h2);
        @(posedge i_clk);
        i_single_clk <= 1'b0;
    endtask

    // Outputs released and busy flags clear once traffic stops
    task automatic s_idle_release();
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        check("rdata_oe", {35'h0, link.rdata_oe}, 36'h0);
        check("rd_busy", {35'h0, o_rd_busy}, 36'h0);
        check("wr_busy", {35'h0, o_wr_busy}, 36'h0);
    endtask

    // Main sequence
    initial begin
        i_clk = 1'b0;
        i_rstn = 1'b0;
        i_single_clk = 1'b0;
        i_rd_req = 1'b0;
        i_rd_addr = '0;
        i_wr_req = 1'b0;
        i_wr_addr = '0;
        i_wr_data = '0;
        i_wr_sel_n = 16'hffff;
        num_errors = 0;
        total_checks = 0;
        cycles = 0;
        for (int i = 0; i < 32; i++) mem[i] = 36'h0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        s_full_burst();
        s_lane_masks();
        s_concurrent();
        s_single_clock();
        s_idle_release();
        conclude();
    end
endmodule
